//--- hw/rptc_reset_park_testmode_control.sv
// Overview of operation
// - Active-low reset; rising edge starts self-configuration
// - No output active while reset is low
// - All eight test pins high-impedance during reset
// - Sample test pins about 1.5us after release
// - After sampling, drive test pins as outputs
// - Any high sampled pin selects a test mode
// - Normal mode: pins are reserved test outputs
// - Active-low park request triggers fast mirror park
`timescale 1ns/1ps
module rptc_reset_park_testmode_control #(
    parameter int unsigned SAMPLE_CYCLES = rptc_pkg::SAMPLE_DELAY_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic power_on_reset_n,
    input wire logic fast_park_req_n,
    input wire logic manufacturing_test_enable,
    input wire logic scan_chain_reset_n,
    input wire logic [7:0] testPinIn,
    input wire logic [7:0] testDataOut,
    output logic [7:0] testPinOut,
    output logic [7:0] testPinOe,
    output logic [7:0] testModeSel,
    output logic configStart,
    output logic parkReq,
    output logic normalMode,
    output logic mfgTestMode
);
    logic [1:0] porSync_r;
    logic [1:0] parkSync_r;
    logic [1:0] mfgSync_r;
    logic [1:0] scanSync_r;
    logic [7:0] pinSync0_r;
    logic [7:0] pinSync1_r;
    logic porPrev_r;
    logic [rptc_pkg::CNT_W-1:0] waitCnt_r;
    rptc_pkg::rptc_state_t state_r;
    rptc_pkg::rptc_state_t state_nxt;
    logic [7:0] testSel_r;
    logic [7:0] pinOut_r;
    logic [7:0] pinOe_r;
    logic cfgStart_r;
    logic park_r;
    logic normal_r;
    logic mfg_r;

    wire logic porLevel = porSync_r[1];
    wire logic porRise = porLevel & ~porPrev_r;
    localparam int unsigned WAIT_LAST_INT = SAMPLE_CYCLES - 1;
    localparam logic [rptc_pkg::CNT_W-1:0] WAIT_LAST = WAIT_LAST_INT[rptc_pkg::CNT_W-1:0];
    wire logic waitDone = (waitCnt_r == WAIT_LAST);
    // A reset that drops in the sampling cycle must not turn the pins into outputs
    wire logic sampleNow = (state_r == rptc_pkg::ST_WAIT) && waitDone && porLevel;
    wire logic inRun = (state_r == rptc_pkg::ST_RUN) && porLevel;
    // Scan reset and test enable are only tied off; they count as test mode when high
    wire logic testForced = mfgSync_r[1] | scanSync_r[1];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rptc_pkg::ST_HELD: begin
                if (porRise) begin
                    state_nxt = rptc_pkg::ST_WAIT;
                end
            end
            rptc_pkg::ST_WAIT: begin
                if (sampleNow) begin
                    state_nxt = rptc_pkg::ST_RUN;
                end
            end
            rptc_pkg::ST_RUN: state_nxt = rptc_pkg::ST_RUN;
            default: state_nxt = rptc_pkg::ST_HELD;
        endcase
        if (!porLevel) begin
            state_nxt = rptc_pkg::ST_HELD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            porSync_r <= 2'h0;
            parkSync_r <= 2'h3;
            mfgSync_r <= 2'h0;
            scanSync_r <= 2'h0;
            pinSync0_r <= 8'h00;
            pinSync1_r <= 8'h00;
            porPrev_r <= 1'b0;
        end else begin
            porSync_r <= {porSync_r[0], power_on_reset_n};
            parkSync_r <= {parkSync_r[0], fast_park_req_n};
            mfgSync_r <= {mfgSync_r[0], manufacturing_test_enable};
            scanSync_r <= {scanSync_r[0], scan_chain_reset_n};
            pinSync0_r <= testPinIn;
            pinSync1_r <= pinSync0_r;
            porPrev_r <= porLevel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= rptc_pkg::ST_HELD;
            waitCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == rptc_pkg::ST_WAIT && porLevel) begin
                waitCnt_r <= waitCnt_r + 1'b1;
            end else begin
                waitCnt_r <= '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !porLevel) begin
            testSel_r <= rptc_pkg::TEST_SEL_RST;
        end else if (sampleNow) begin
            testSel_r <= pinSync1_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinOut_r <= rptc_pkg::TEST_OUT_RST;
            pinOe_r <= rptc_pkg::TEST_OE_RST;
            cfgStart_r <= 1'b0;
            park_r <= 1'b0;
            normal_r <= 1'b0;
            mfg_r <= 1'b0;
        end else begin
            pinOe_r <= (inRun || sampleNow) ? 8'hFF : 8'h00;
            pinOut_r <= (inRun || sampleNow) ? testDataOut : 8'h00;
            cfgStart_r <= porRise;
            park_r <= porLevel & ~parkSync_r[1];
            normal_r <= inRun && (testSel_r == 8'h00) && !testForced;
            mfg_r <= porLevel & testForced;
        end
    end

    assign testPinOut = pinOut_r;
    assign testPinOe = pinOe_r;
    assign testModeSel = testSel_r;
    assign configStart = cfgStart_r;
    assign parkReq = park_r;
    assign normalMode = normal_r;
    assign mfgTestMode = mfg_r;

    int unsigned heldCnt;
    always_ff @(posedge sys_clk) begin
        if (rst || porLevel) begin
            heldCnt <= 0;
        end else if (heldCnt < 1000) begin
            heldCnt <= heldCnt + 1;
        end
    end

    // Cycles since the last detected release, saturating; pins the sampling point
    int unsigned sinceRise;
    always_ff @(posedge sys_clk) begin
        if (rst || !porLevel) begin
            sinceRise <= 0;
        end else if (porRise) begin
            sinceRise <= 1;
        end else if (sinceRise < 1000) begin
            sinceRise <= sinceRise + 1;
        end
    end

    chk_reset_pins_float: assert property (@(posedge sys_clk) disable iff (rst)
        (!porLevel && heldCnt > 1) |-> (testPinOe == 8'h00))
        else $error("test pins driven during reset");
    chk_reset_outs_idle: assert property (@(posedge sys_clk) disable iff (rst)
        (heldCnt > 1) |-> !(parkReq || normalMode || configStart || mfgTestMode))
        else $error("output active during reset");
    chk_cfg_start_edge: assert property (@(posedge sys_clk) disable iff (rst)
        porRise |=> configStart)
        else $error("config start missed");
    chk_sample_then_drive: assert property (@(posedge sys_clk) disable iff (rst)
        sampleNow |=> (testPinOe == 8'hFF))
        else $error("pins not driven after sampling");
    chk_sample_delay_exact: assert property (@(posedge sys_clk) disable iff (rst)
        sampleNow |-> (sinceRise == SAMPLE_CYCLES))
        else $error("sampling at wrong delay");
    chk_sample_not_missed: assert property (@(posedge sys_clk) disable iff (rst)
        (porLevel && sinceRise == SAMPLE_CYCLES) |-> sampleNow)
        else $error("sampling point missed");
    chk_sel_captured: assert property (@(posedge sys_clk) disable iff (rst)
        sampleNow |=> (testModeSel == $past(pinSync1_r)))
        else $error("selection not captured");
    chk_sel_held: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == rptc_pkg::ST_RUN && porLevel) |=> $stable(testModeSel) || !porLevel)
        else $error("selection changed in run");
    chk_park_follow: assert property (@(posedge sys_clk) disable iff (rst)
        (porLevel && !parkSync_r[1]) |=> parkReq)
        else $error("park not requested");
    chk_normal_outs: assert property (@(posedge sys_clk) disable iff (rst)
        normalMode |-> (testModeSel == 8'h00))
        else $error("normal mode with test selection");
    chk_cfg_one_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        configStart |=> !configStart)
        else $error("config start longer than one cycle");
    chk_wait_pins_float: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == rptc_pkg::ST_WAIT) |-> (testPinOe == 8'h00))
        else $error("test pins driven before sampling");
    chk_park_release: assert property (@(posedge sys_clk) disable iff (rst)
        parkSync_r[1] |=> !parkReq)
        else $error("park held after request gone");
    chk_forced_not_normal: assert property (@(posedge sys_clk) disable iff (rst)
        testForced |=> !normalMode)
        else $error("normal mode while test forced");

    cov_config_start: cover property (@(posedge sys_clk) disable iff (rst) porRise ##[1:300] sampleNow);
    cov_test_mode: cover property (@(posedge sys_clk) disable iff (rst) sampleNow && pinSync1_r != 8'h00);
    cov_fast_park: cover property (@(posedge sys_clk) disable iff (rst) inRun && parkReq);
    cov_normal_run: cover property (@(posedge sys_clk) disable iff (rst) normalMode);
    cov_mfg_mode: cover property (@(posedge sys_clk) disable iff (rst) mfgTestMode);
endmodule

//--- hw/rptc_pkg.sv
package rptc_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned SAMPLE_DELAY_PS = 1500000;
    // Least delay, rounded up to whole cycles
    localparam int unsigned SAMPLE_DELAY_CYC = (SAMPLE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned TEST_PIN_COUNT = 8;
    localparam int unsigned CNT_W = 8;
    // Reset values
    localparam logic [7:0] TEST_SEL_RST = 8'h00;
    localparam logic [7:0] TEST_OUT_RST = 8'h00;
    localparam logic [7:0] TEST_OE_RST = 8'h00;

    typedef enum {
        ST_HELD,
        ST_WAIT,
        ST_RUN
    } rptc_state_t;

    typedef struct packed {
        logic parkActive;
        logic configStart;
        logic testModeActive;
        logic normalMode;
    } rptc_status_t;
endpackage

//--- verif/rptc_pmic_model.sv
`timescale 1ns/1ps
module rptc_pmic_model #(
    parameter int STABLE_CYCLES = 3
) (
    input wire logic sys_clk,
    input wire logic supplyOk,
    input wire logic powerFail,
    input wire logic [7:0] extPullup,
    input wire logic [7:0] testPinOut,
    input wire logic [7:0] testPinOe,
    output logic power_on_reset_n = 1'b0,
    output logic fast_park_req_n = 1'b1,
    output wire logic [7:0] testPinIn
);
    int stableCnt = 0;
    // Release only after supplies have settled for a while
    always @(negedge sys_clk) begin
        stableCnt = supplyOk ? stableCnt + 1 : 0;
        power_on_reset_n <= stableCnt > STABLE_CYCLES;
        fast_park_req_n <= !(powerFail && power_on_reset_n);
    end
    // Undriven pins fall to the pullup fitted, else the weak pulldown
    assign testPinIn = (testPinOe & testPinOut) | (~testPinOe & extPullup);
endmodule

//--- verif/test_reset_park_testmode_control.sv
`timescale 1ns/1ps
module test_reset_park_testmode_control;
    localparam int SAMPLE = 4;
    logic sys_clk = 0, rst = 1, supplyOk = 0, powerFail = 0;
    logic mfgEn = 0, scanRst = 0, normDue = 0;
    logic [7:0] extPullup = 8'h00, testDataOut = 8'h00, prevOe = 8'h00;
    logic [8:0] expNote;
    wire logic power_on_reset_n, fast_park_req_n, configStart, parkReq, normalMode, mfgTestMode;
    wire logic [7:0] testPinIn, testPinOut, testPinOe, testModeSel;
    int num_errors = 0, comparisons = 0, cycles = 0, pulses = 0;
    integer seed = 32'hc0e6d8e7;
    logic [8:0] expQ[$];
    always #4 sys_clk = ~sys_clk;
    rptc_pmic_model PMIC (.sys_clk(sys_clk), .supplyOk(supplyOk), .powerFail(powerFail),
        .extPullup(extPullup), .testPinOut(testPinOut), .testPinOe(testPinOe),
        .power_on_reset_n(power_on_reset_n), .fast_park_req_n(fast_park_req_n),
        .testPinIn(testPinIn));
    // Test-enable and scan reset held low as a board would, bar two test runs
    rptc_reset_park_testmode_control #(.SAMPLE_CYCLES(SAMPLE)) DUT (.sys_clk(sys_clk),
        .rst(rst), .power_on_reset_n(power_on_reset_n), .fast_park_req_n(fast_park_req_n),
        .manufacturing_test_enable(mfgEn), .scan_chain_reset_n(scanRst), .testPinIn(testPinIn),
        .testDataOut(testDataOut), .testPinOut(testPinOut), .testPinOe(testPinOe),
        .testModeSel(testModeSel), .configStart(configStart), .parkReq(parkReq),
        .normalMode(normalMode), .mfgTestMode(mfgTestMode));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end
    // Selection is judged when the pins turn to outputs, normal mode one cycle later
    always @(posedge sys_clk) begin
        if (configStart === 1'b1) pulses++;
        #1;
        if (normDue) begin
            cmp1(normalMode, expNote[8]);
            normDue = 0;
        end
        if (testPinOe === 8'hFF && prevOe !== 8'hFF && expQ.size() > 0) begin
            expNote = expQ.pop_front();
            cmp8(testModeSel, expNote[7:0]);
            normDue = 1;
        end
        prevOe = testPinOe;
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 0;
        for (int i = 0; i < 6; i++) begin
            @(negedge sys_clk);
            supplyOk = 0;
            extPullup = (i < 2) ? 8'h00 : 8'($random(seed));
            repeat (6) @(negedge sys_clk);
            cmp8(testPinOe, 8'h00);
            cmp8(testModeSel, 8'h00);
            cmp1(parkReq | configStart | normalMode | mfgTestMode, 1'b0);
            mfgEn = (i == 4);
            scanRst = (i == 5);
            pulses = 0;
            expQ.push_back({extPullup == 8'h00 && !mfgEn && !scanRst, extPullup});
            supplyOk = 1;
            repeat (SAMPLE + 20) @(negedge sys_clk);
            cmp1(pulses == 1, 1'b1);
            cmp1(mfgTestMode, mfgEn | scanRst);
            testDataOut = 8'($random(seed));
            extPullup = ~extPullup;
            repeat (3) @(negedge sys_clk);
            cmp8(testPinOut, testDataOut);
            cmp8(testModeSel, ~extPullup);
            powerFail = 1;
            repeat (5) @(negedge sys_clk);
            cmp1(parkReq, 1'b1);
            powerFail = 0;
            repeat (5) @(negedge sys_clk);
            cmp1(parkReq, 1'b0);
        end
        cmp8(8'(expQ.size()), 8'h00);
        close_out();
    end
endmodule
